// >>> pkg/zoom_regs_pkg.sv
// constants and carrier types for the context A vertical zoom register slice
package zoom_regs_pkg;

    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam int DIM_W = 11;

    // register offsets
    localparam logic [8:0] OFS_VPAN_A = 9'h1a8;
    localparam logic [8:0] OFS_VZOOM_A = 9'h1a9;
    localparam logic [8:0] OFS_VSIZE_A = 9'h1aa;
    localparam logic [8:0] OFS_CUR_HZOOM = 9'h1ab;
    localparam logic [8:0] OFS_CUR_VZOOM = 9'h1ac;

    // field positions
    localparam int DIM_LSB = 0;
    localparam int DIM_MSB = 10;
    localparam int PAN_ORIGIN_BIT = 14;

    // reset values
    localparam logic [15:0] RST_VPAN_A = 16'h0000;
    localparam logic [15:0] RST_VZOOM_A = 16'h0400;
    localparam logic [15:0] RST_VSIZE_A = 16'h0200;
    localparam logic [10:0] RST_CUR_HZOOM = 11'h500;
    localparam logic [10:0] RST_CUR_VZOOM = 11'h400;

    // window geometry
    localparam logic [11:0] CENTRE_ROW = 12'h200;
    localparam logic [10:0] FULL_WIDTH = 11'h500;
    localparam logic [10:0] FULL_HEIGHT = 11'h400;

    // register access request from the serial programming decoder
    typedef struct packed {
        logic rd;
        logic wr;
        logic [8:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    // register answer
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } reg_rsp_t;

    // automatic zoom request from the zoom control logic
    typedef struct packed {
        logic zoom_in;
        logic zoom_out;
        logic [7:0] step_x;
        logic [7:0] step_y;
    } zoom_cmd_t;

endpackage

// >>> rtl/zoom_stepper.sv
// current zoom window tracker stepped by automatic zoom
`timescale 1ns/100ps
module zoom_stepper (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // zoom request
    input wire zoom_regs_pkg::zoom_cmd_t cmd,
    // current window
    output logic [10:0] cur_w,
    output logic [10:0] cur_h
);

    typedef struct packed {
        logic [10:0] w;
        logic [10:0] h;
    } step_state_t;

    step_state_t state_ff;
    step_state_t nxt_state;
    logic [11:0] w_up;
    logic [11:0] h_up;

    always_comb
    begin
        nxt_state = state_ff;
        w_up = {1'b0, state_ff.w} + {4'h0, cmd.step_x};
        h_up = {1'b0, state_ff.h} + {4'h0, cmd.step_y};
        // both starts at once is ambiguous, so neither is taken
        if (cmd.zoom_in && !cmd.zoom_out)
        begin
            // never shrink to zero or wrap below the step
            if (state_ff.w > {3'h0, cmd.step_x})
            begin
                nxt_state.w = state_ff.w - {3'h0, cmd.step_x};
            end
            if (state_ff.h > {3'h0, cmd.step_y})
            begin
                nxt_state.h = state_ff.h - {3'h0, cmd.step_y};
            end
        end
        else if (cmd.zoom_out && !cmd.zoom_in)
        begin
            nxt_state.w = (w_up > {1'b0, zoom_regs_pkg::FULL_WIDTH}) ?
                zoom_regs_pkg::FULL_WIDTH : w_up[10:0];
            nxt_state.h = (h_up > {1'b0, zoom_regs_pkg::FULL_HEIGHT}) ?
                zoom_regs_pkg::FULL_HEIGHT : h_up[10:0];
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= {zoom_regs_pkg::RST_CUR_HZOOM, zoom_regs_pkg::RST_CUR_VZOOM};
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign cur_w = state_ff.w;
    assign cur_h = state_ff.h;

endmodule

// >>> rtl/reducer_zoom_window_regs.sv
// context A vertical pan, zoom and size registers with current zoom readback
// Operation
// - pan bit 14 picks origin: clear is row zero, set is centred row 512
// - pan bits 10:0 unsigned from row zero, or two's complement from row 512
// - vertical zoom height is 11 bits at 10:0, reset 0x0400
// - vertical output size is 11 bits at 10:0, reset 0x0200
// - current horizontal zoom width readable in bits 10:0, read only
// - current vertical zoom height readable in bits 10:0, read only
// - ZOOM_CMD zoom_in steps zoom in, zoom_out steps zoom out, both at once step neither
`timescale 1ns/100ps
module reducer_zoom_window_regs (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic NRST,
    // register port from the serial programming decoder
    input wire zoom_regs_pkg::reg_req_t REG_REQ,
    output zoom_regs_pkg::reg_rsp_t REG_RSP,
    // automatic zoom from the zoom control logic
    input wire zoom_regs_pkg::zoom_cmd_t ZOOM_CMD,
    // to the scaler datapath
    output logic [10:0] VPAN_OFFSET,
    output logic VPAN_CENTRED,
    output logic signed [11:0] VSTART_ROW,
    output logic [10:0] VZOOM_HEIGHT,
    output logic [10:0] VOUT_SIZE,
    output logic [10:0] CUR_ZOOM_WIDTH,
    output logic [10:0] CUR_ZOOM_HEIGHT
);

    typedef struct packed {
        logic pan_centred;
        logic [10:0] pan;
        logic [10:0] zoom_h;
        logic [10:0] out_size;
        logic signed [11:0] start_row;
        logic [10:0] cur_w;
        logic [10:0] cur_h;
        zoom_regs_pkg::reg_rsp_t rsp;
    } regs_state_t;

    regs_state_t state_ff;
    regs_state_t nxt_state;
    logic [10:0] live_w;
    logic [10:0] live_h;
    logic [15:0] rd_word;

    // read words, reserved bits held at zero
    logic [15:0] pan_word;
    logic [15:0] zoom_word;
    logic [15:0] size_word;
    logic [15:0] cur_w_word;
    logic [15:0] cur_h_word;

    // start row for each origin choice
    logic signed [11:0] pan_ext;
    logic signed [11:0] centred_row;
    logic signed [11:0] plain_row;

    // reset release retimed to the clock
    logic nrst_meta_ff;
    logic nrst_sync_ff;

    zoom_stepper u_stepper (
        .clk(CLK_SYS),
        .nrst(nrst_sync_ff),
        .cmd(ZOOM_CMD),
        .cur_w(live_w),
        .cur_h(live_h)
    );

    always_comb
    begin
        nxt_state = state_ff;
        rd_word = 16'h0000;
        // reserved bits read zero so a software copy only has to mask them
        pan_word = 16'h0000;
        pan_word[zoom_regs_pkg::PAN_ORIGIN_BIT] = state_ff.pan_centred;
        pan_word[zoom_regs_pkg::DIM_MSB:zoom_regs_pkg::DIM_LSB] = state_ff.pan;
        zoom_word = 16'h0000;
        zoom_word[zoom_regs_pkg::DIM_MSB:zoom_regs_pkg::DIM_LSB] = state_ff.zoom_h;
        size_word = 16'h0000;
        size_word[zoom_regs_pkg::DIM_MSB:zoom_regs_pkg::DIM_LSB] = state_ff.out_size;
        cur_w_word = 16'h0000;
        cur_w_word[zoom_regs_pkg::DIM_MSB:zoom_regs_pkg::DIM_LSB] = live_w;
        cur_h_word = 16'h0000;
        cur_h_word[zoom_regs_pkg::DIM_MSB:zoom_regs_pkg::DIM_LSB] = live_h;

        pan_ext = {state_ff.pan[zoom_regs_pkg::DIM_MSB], state_ff.pan};
        centred_row = $signed(zoom_regs_pkg::CENTRE_ROW) + pan_ext;
        plain_row = $signed({1'b0, state_ff.pan});

        nxt_state.rsp.valid = 1'b0;
        nxt_state.cur_w = live_w;
        nxt_state.cur_h = live_h;
        // a read and a write in one cycle return the old value
        if (REG_REQ.wr)
        begin
            unique case (REG_REQ.addr)
                zoom_regs_pkg::OFS_VPAN_A:
                begin
                    nxt_state.pan_centred = REG_REQ.wdata[zoom_regs_pkg::PAN_ORIGIN_BIT];
                    nxt_state.pan =
                        REG_REQ.wdata[zoom_regs_pkg::DIM_MSB:zoom_regs_pkg::DIM_LSB];
                end
                zoom_regs_pkg::OFS_VZOOM_A:
                begin
                    // ordering against output size is left to software
                    nxt_state.zoom_h =
                        REG_REQ.wdata[zoom_regs_pkg::DIM_MSB:zoom_regs_pkg::DIM_LSB];
                end
                zoom_regs_pkg::OFS_VSIZE_A:
                begin
                    nxt_state.out_size =
                        REG_REQ.wdata[zoom_regs_pkg::DIM_MSB:zoom_regs_pkg::DIM_LSB];
                end
                zoom_regs_pkg::OFS_CUR_HZOOM,
                zoom_regs_pkg::OFS_CUR_VZOOM:
                begin
                    // readbacks follow the stepper alone, so a write is dropped
                    nxt_state.rsp.valid = 1'b0;
                end
                default:
                begin
                    // unmapped offsets drop the write
                    nxt_state.rsp.valid = 1'b0;
                end
            endcase
        end
        // start row follows the stored pan, one cycle behind it and two behind a write
        if (state_ff.pan_centred)
        begin
            nxt_state.start_row = centred_row;
        end
        else
        begin
            nxt_state.start_row = plain_row;
        end
        // unmapped reads answer zero so the decoder never stalls
        if (REG_REQ.rd)
        begin
            unique case (REG_REQ.addr)
                zoom_regs_pkg::OFS_VPAN_A:
                begin
                    rd_word = pan_word;
                end
                zoom_regs_pkg::OFS_VZOOM_A:
                begin
                    rd_word = zoom_word;
                end
                zoom_regs_pkg::OFS_VSIZE_A:
                begin
                    rd_word = size_word;
                end
                zoom_regs_pkg::OFS_CUR_HZOOM:
                begin
                    // live value, not the output copy that lags it
                    rd_word = cur_w_word;
                end
                zoom_regs_pkg::OFS_CUR_VZOOM:
                begin
                    rd_word = cur_h_word;
                end
                default:
                begin
                    rd_word = 16'h0000;
                end
            endcase
            nxt_state.rsp.valid = 1'b1;
            nxt_state.rsp.data = rd_word;
        end
    end

    // release retimed so no register leaves reset on a split edge
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            nrst_meta_ff <= 1'b0;
            nrst_sync_ff <= 1'b0;
        end
        else
        begin
            nrst_meta_ff <= 1'b1;
            nrst_sync_ff <= nrst_meta_ff;
        end
    end

    always_ff @(posedge CLK_SYS or negedge nrst_sync_ff)
    begin
        if (!nrst_sync_ff)
        begin
            state_ff.pan_centred <= zoom_regs_pkg::RST_VPAN_A[zoom_regs_pkg::PAN_ORIGIN_BIT];
            state_ff.pan <= zoom_regs_pkg::RST_VPAN_A[10:0];
            state_ff.zoom_h <= zoom_regs_pkg::RST_VZOOM_A[10:0];
            state_ff.out_size <= zoom_regs_pkg::RST_VSIZE_A[10:0];
            state_ff.start_row <= 12'sh000;
            state_ff.cur_w <= zoom_regs_pkg::RST_CUR_HZOOM;
            state_ff.cur_h <= zoom_regs_pkg::RST_CUR_VZOOM;
            state_ff.rsp <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign REG_RSP = state_ff.rsp;
    assign VPAN_OFFSET = state_ff.pan;
    assign VPAN_CENTRED = state_ff.pan_centred;
    assign VSTART_ROW = state_ff.start_row;
    assign VZOOM_HEIGHT = state_ff.zoom_h;
    assign VOUT_SIZE = state_ff.out_size;
    assign CUR_ZOOM_WIDTH = state_ff.cur_w;
    assign CUR_ZOOM_HEIGHT = state_ff.cur_h;

endmodule

// >>> tb/zoom_window_assertions.sv
// checker for the zoom window register slice
`timescale 1ns/100ps
module zoom_window_checker (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic NRST,
    // watched ports
    input wire zoom_regs_pkg::reg_req_t REG_REQ,
    input wire zoom_regs_pkg::reg_rsp_t REG_RSP,
    input wire zoom_regs_pkg::zoom_cmd_t ZOOM_CMD,
    input wire logic [10:0] VPAN_OFFSET,
    input wire logic VPAN_CENTRED,
    input wire logic signed [11:0] VSTART_ROW,
    input wire logic [10:0] VZOOM_HEIGHT,
    input wire logic [10:0] VOUT_SIZE,
    input wire logic [10:0] CUR_ZOOM_WIDTH,
    input wire logic [10:0] CUR_ZOOM_HEIGHT
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    property p_origin;
        REG_REQ.wr && REG_REQ.addr == 9'h1a8 |=> VPAN_CENTRED == $past(REG_REQ.wdata[14]);
    endproperty
    a_origin: assert property (p_origin) else $error("pan origin bit wrong");
    // start row lags the pan register by one cycle
    property p_start;
        VSTART_ROW == ($past(VPAN_CENTRED)
            ? 12'sh200 + $signed({$past(VPAN_OFFSET[10]), $past(VPAN_OFFSET)})
            : $signed({1'b0, $past(VPAN_OFFSET)}));
    endproperty
    a_start: assert property (p_start) else $error("start row wrong");
    property p_vzoom;
        REG_REQ.wr && REG_REQ.addr == 9'h1a9 |=> VZOOM_HEIGHT == $past(REG_REQ.wdata[10:0]);
    endproperty
    a_vzoom: assert property (p_vzoom) else $error("zoom height wrong");
    property p_vsize;
        REG_REQ.wr && REG_REQ.addr == 9'h1aa |=> VOUT_SIZE == $past(REG_REQ.wdata[10:0]);
    endproperty
    a_vsize: assert property (p_vsize) else $error("output size wrong");
    // only a zoom step may move the window, never a register write
    property p_hold;
        !(ZOOM_CMD.zoom_in ^ ZOOM_CMD.zoom_out) |-> ##2
            $stable(CUR_ZOOM_WIDTH) && $stable(CUR_ZOOM_HEIGHT);
    endproperty
    a_hold: assert property (p_hold) else $error("window moved");
    property p_zin;
        ZOOM_CMD.zoom_in && !ZOOM_CMD.zoom_out |-> ##2 CUR_ZOOM_WIDTH ==
            ($past(CUR_ZOOM_WIDTH) > $past(ZOOM_CMD.step_x, 2)
            ? $past(CUR_ZOOM_WIDTH) - $past(ZOOM_CMD.step_x, 2) : $past(CUR_ZOOM_WIDTH));
    endproperty
    a_zin: assert property (p_zin) else $error("zoom in step wrong");
    property p_zout;
        ZOOM_CMD.zoom_out && !ZOOM_CMD.zoom_in |-> ##2 CUR_ZOOM_HEIGHT ==
            ({1'b0, $past(CUR_ZOOM_HEIGHT)} + $past(ZOOM_CMD.step_y, 2) > 12'h400
            ? 11'h400 : $past(CUR_ZOOM_HEIGHT) + $past(ZOOM_CMD.step_y, 2));
    endproperty
    a_zout: assert property (p_zout) else $error("zoom out step wrong");
    property p_rd_w;
        REG_REQ.rd && REG_REQ.addr == 9'h1ab |=>
            REG_RSP.valid && REG_RSP.data == {5'h00, CUR_ZOOM_WIDTH};
    endproperty
    a_rd_w: assert property (p_rd_w) else $error("width readback wrong");
    property p_rd_h;
        REG_REQ.rd && REG_REQ.addr == 9'h1ac |=>
            REG_RSP.valid && REG_RSP.data == {5'h00, CUR_ZOOM_HEIGHT};
    endproperty
    a_rd_h: assert property (p_rd_h) else $error("height readback wrong");
    c_zin: cover property (ZOOM_CMD.zoom_in);
    c_clamp: cover property (ZOOM_CMD.zoom_out ##2 CUR_ZOOM_HEIGHT == 11'h400);
    c_centred: cover property (VPAN_CENTRED);
endmodule
bind reducer_zoom_window_regs zoom_window_checker i_zoom_window_checker (.*);

// >>> tb/tb_top.sv
// register sequence bench for the zoom window slice
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    zoom_regs_pkg::reg_req_t req = '0;
    zoom_regs_pkg::zoom_cmd_t zc = '0;
    zoom_regs_pkg::reg_rsp_t rsp;
    logic [10:0] pan, vz, vs, cw, ch;
    logic [15:0] last_rd;
    logic ctr;
    logic signed [11:0] vst;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    always #10 clk = ~clk;
    reducer_zoom_window_regs i_reducer_zoom_window_regs (.CLK_SYS(clk), .NRST(nrst),
        .REG_REQ(req), .REG_RSP(rsp), .ZOOM_CMD(zc), .VPAN_OFFSET(pan), .VPAN_CENTRED(ctr),
        .VSTART_ROW(vst), .VZOOM_HEIGHT(vz), .VOUT_SIZE(vs), .CUR_ZOOM_WIDTH(cw),
        .CUR_ZOOM_HEIGHT(ch));
    task automatic close_out();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        #1;
        req.wr = 1'b0;
    endtask
    // answer stands one cycle, so it is sampled just after the taking edge
    task automatic rd(input logic [8:0] a, input logic [15:0] e);
        @(posedge clk);
        #1;
        req.rd = 1'b1;
        req.addr = a;
        @(posedge clk);
        #1;
        req.rd = 1'b0;
        cmp("valid", 16'h0001, {15'h0000, rsp.valid});
        cmp("rdata", e, rsp.data);
        last_rd = rsp.data;
    endtask
    task automatic zoom(input logic zin, input logic zout, input logic [7:0] sx,
        input logic [7:0] sy);
        @(posedge clk);
        #1;
        zc = '{zoom_in: zin, zoom_out: zout, step_x: sx, step_y: sy};
        @(posedge clk);
        #1;
        zc = '0;
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        #1;
        nrst = 1'b1;
        // the design retimes its reset release by two edges
        repeat (2) @(posedge clk);
        rd(9'h1a8, 16'h0000);
        rd(9'h1a9, 16'h0400);
        rd(9'h1aa, 16'h0200);
        rd(9'h1ab, 16'h0500);
        rd(9'h1ac, 16'h0400);
        rd(9'h1ad, 16'h0000);
        wr(9'h1a8, 16'hffff);
        cmp("vpan", 16'h07ff, {5'h00, pan});
        cmp("centred", 16'h0001, {15'h0000, ctr});
        rd(9'h1a8, 16'h47ff);
        cmp("vstart", 16'h01ff, {4'h0, vst});
        wr(9'h1a8, 16'h0123);
        rd(9'h1a8, 16'h0123);
        cmp("vstart", 16'h0123, {4'h0, vst});
        wr(9'h1a9, 16'hffff);
        rd(9'h1a9, 16'h07ff);
        wr(9'h1aa, 16'hf155);
        cmp("vsize", 16'h0155, {5'h00, vs});
        wr(9'h1ab, 16'h0000);
        wr(9'h1ac, 16'h0001);
        rd(9'h1ab, 16'h0500);
        rd(9'h1ac, 16'h0400);
        zoom(1'b1, 1'b0, 8'h05, 8'h04);
        rd(9'h1ab, 16'h04fb);
        cmp("cur_w", 16'h04fb, {5'h00, cw});
        rd(9'h1ac, 16'h03fc);
        cmp("cur_h", 16'h03fc, {5'h00, ch});
        wr(9'h1a9, last_rd & 16'h0fff);
        cmp("vzoom", 16'h03fc, {5'h00, vz});
        wr(9'h1aa, last_rd & 16'h0fff);
        cmp("vsize", 16'h03fc, {5'h00, vs});
        zoom(1'b1, 1'b1, 8'h10, 8'h10);
        rd(9'h1ab, 16'h04fb);
        rd(9'h1ac, 16'h03fc);
        zoom(1'b0, 1'b1, 8'h10, 8'h10);
        rd(9'h1ab, 16'h0500);
        rd(9'h1ac, 16'h0400);
        cmp("cur_w", 16'h0500, {5'h00, cw});
        cmp("cur_h", 16'h0400, {5'h00, ch});
        close_out();
    end
    // ceiling far above the few dozen cycles the sequence needs
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            error_cnt++;
            close_out();
        end
    end
endmodule
